// ==== logic/pirq_ahb_slave.sv ====
// pirq_ahb_slave: ahb-lite slave answering with zero wait states.
// assumes single word transfers; responses are always okay.
`timescale 1ns/1ps
module pirq_ahb_slave
(
    input  wire logic        i_clk_sys,   // system clock
    input  wire logic        i_rst,       // sync reset, high
    input  wire logic        i_ce,        // clock enable
    input  wire logic        i_hsel,      // slave select
    input  wire logic [31:0] i_haddr,     // address
    input  wire logic [1:0]  i_htrans,    // transfer type
    input  wire logic        i_hwrite,    // write flag
    input  wire logic [31:0] i_hwdata,    // write data
    input  wire logic        i_hready,    // bus ready
    output logic      [31:0] o_hrdata,    // read data
    pirq_reg_if.slave_side   reg_bus      // to register bank
);

    logic        wr_pend_reg;
    logic [11:0] addr_reg;
    logic        take;

    assign take = i_hsel && i_hready && i_htrans == pirq_pkg::HTRANS_NONSEQ;

    // capture address phase
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end
        else if (i_ce)
        begin
            wr_pend_reg <= take && i_hwrite;
            if (take)
                addr_reg <= {i_haddr[11:2], 2'b00};
        end
    end

    // data phase write and read return
    assign reg_bus.wr_en = wr_pend_reg && i_ce;
    assign reg_bus.addr  = addr_reg;
    assign reg_bus.wdata = i_hwdata[7:0];
    assign o_hrdata      = {24'h000000, reg_bus.rdata};
endmodule

// ==== logic/pirq_bank.sv ====
// pirq_bank: peripheral interrupt enable and flag registers, gated request,
// sticky event status with mask for the host interrupt line.
// assumes peripheral event inputs are one-cycle or level pulses, synchronous.
`timescale 1ns/1ps
module pirq_bank
(
    input  wire logic        i_clk_sys,        // system clock
    input  wire logic        i_rst,            // sync reset, high
    input  wire logic        i_ce,             // clock enable
    input  wire logic        i_hsel,           // ahb select
    input  wire logic [31:0] i_haddr,          // ahb address
    input  wire logic [1:0]  i_htrans,         // ahb transfer type
    input  wire logic        i_hwrite,         // ahb write
    input  wire logic [2:0]  i_hsize,          // ahb size
    input  wire logic [31:0] i_hwdata,         // ahb write data
    input  wire logic        i_hready,         // ahb bus ready
    output logic      [31:0] o_hrdata,         // ahb read data
    output logic             o_hreadyout,      // ahb ready out
    output logic             o_hresp,          // ahb response
    input  wire logic        i_timer1_gate,    // timer1 gate event
    input  wire logic        i_converter1,     // converter 1 done
    input  wire logic        i_serial_rx,      // serial receive event
    input  wire logic        i_serial_tx,      // serial transmit event
    input  wire logic        i_sync_serial,    // sync serial event
    input  wire logic        i_timer2_match,   // timer2 period match
    input  wire logic        i_timer1_overflow, // timer1 overflow
    input  wire logic        i_converter2,     // converter 2 done
    input  wire logic        i_bus_collision,  // bus collision event
    output logic             o_periph_pending, // enabled flag pending
    output logic             o_core_request,   // request to sequencer
    output logic             o_irq             // host interrupt line
);

    pirq_reg_if reg_bus ();

    logic [7:0] enable_a_reg;
    logic [7:0] enable_b_reg;
    logic [7:0] flags_a_reg;
    logic [7:0] flags_b_reg;
    logic [7:0] core_ctl_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic       pending_reg;
    logic       request_reg;
    logic       irq_reg;
    logic       any_pending;
    logic       redirect;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] flags_a_next;
    logic [7:0] flags_b_next;
    logic [1:0] irq_stat_next;
    logic [7:0] rdata;

    // write strobe for one offset
    function automatic logic hit(input logic [11:0] offs);
        return reg_bus.wr_en && reg_bus.addr == offs;
    endfunction

    // bus slave, zero wait states
    pirq_ahb_slave u_slave
    (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_hsel    (i_hsel),
        .i_haddr   (i_haddr),
        .i_htrans  (i_htrans),
        .i_hwrite  (i_hwrite),
        .i_hwdata  (i_hwdata),
        .i_hready  (i_hready),
        .o_hrdata  (o_hrdata),
        .reg_bus   (reg_bus.slave_side)
    );

    // fixed bus answers
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // source events placed at their flag positions
    always_comb
    begin
        set_a = 8'h00;
        set_b = 8'h00;
        set_a[pirq_pkg::TIMER1_GATE_BIT]     = i_timer1_gate;
        set_a[pirq_pkg::CONVERTER1_BIT]      = i_converter1;
        set_a[pirq_pkg::SERIAL_RX_BIT]       = i_serial_rx;
        set_a[pirq_pkg::SERIAL_TX_BIT]       = i_serial_tx;
        set_a[pirq_pkg::SYNC_SERIAL_BIT]     = i_sync_serial;
        set_a[pirq_pkg::TIMER2_MATCH_BIT]    = i_timer2_match;
        set_a[pirq_pkg::TIMER1_OVERFLOW_BIT] = i_timer1_overflow;
        set_b[pirq_pkg::CONVERTER2_BIT]      = i_converter2;
        set_b[pirq_pkg::BUS_COLLISION_BIT]   = i_bus_collision;
    end

    // flag next values: write then set, set wins
    always_comb
    begin
        flags_a_next = flags_a_reg;
        flags_b_next = flags_b_reg;
        if (hit(pirq_pkg::FLAGS_A_OFFS))
            flags_a_next = reg_bus.wdata;
        if (hit(pirq_pkg::FLAGS_B_OFFS))
            flags_b_next = reg_bus.wdata;
        flags_a_next = (flags_a_next | set_a) & pirq_pkg::IMPL_A_MASK;
        flags_b_next = (flags_b_next | set_b) & pirq_pkg::IMPL_B_MASK;
    end

    // pending flag registers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            flags_a_reg <= pirq_pkg::BANK_RESET;
            flags_b_reg <= pirq_pkg::BANK_RESET;
        end
        else if (i_ce)
        begin
            flags_a_reg <= flags_a_next;
            flags_b_reg <= flags_b_next;
        end
    end

    // enable registers and core control
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            enable_a_reg <= pirq_pkg::BANK_RESET;
            enable_b_reg <= pirq_pkg::BANK_RESET;
            core_ctl_reg <= pirq_pkg::BANK_RESET;
        end
        else if (i_ce)
        begin
            if (hit(pirq_pkg::ENABLE_A_OFFS))
                enable_a_reg <= reg_bus.wdata & pirq_pkg::IMPL_A_MASK;
            if (hit(pirq_pkg::ENABLE_B_OFFS))
                enable_b_reg <= reg_bus.wdata & pirq_pkg::IMPL_B_MASK;
            if (hit(pirq_pkg::CORE_CTL_OFFS))
                core_ctl_reg <= reg_bus.wdata & pirq_pkg::CORE_MASK;
        end
    end

    // request gating
    pirq_req_gate u_gate
    (
        .i_flags_a   (flags_a_reg),
        .i_flags_b   (flags_b_reg),
        .i_enable_a  (enable_a_reg),
        .i_enable_b  (enable_b_reg),
        .i_periph_en (core_ctl_reg[pirq_pkg::PERIPH_EN_BIT]),
        .i_global_en (core_ctl_reg[pirq_pkg::GLOBAL_EN_BIT]),
        .o_any       (any_pending),
        .o_redirect  (redirect)
    );

    // registered request outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pending_reg <= 1'b0;
            request_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            pending_reg <= any_pending;
            request_reg <= redirect;
        end
    end

    // sticky host events: request rise, enabled pending while blocked
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (hit(pirq_pkg::IRQ_STAT_OFFS))
            irq_stat_next = irq_stat_reg & ~reg_bus.wdata[1:0];
        irq_stat_next[pirq_pkg::EV_REQ_RISE] = irq_stat_next[pirq_pkg::EV_REQ_RISE]
                                               | (redirect & ~request_reg);
        irq_stat_next[pirq_pkg::EV_DEFERRED] = irq_stat_next[pirq_pkg::EV_DEFERRED]
                                               | (any_pending & ~redirect);
    end

    // host status, mask and line
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_stat_reg <= pirq_pkg::IRQ_RESET;
            irq_mask_reg <= pirq_pkg::IRQ_RESET;
            irq_reg      <= 1'b0;
        end
        else if (i_ce)
        begin
            irq_stat_reg <= irq_stat_next;
            if (hit(pirq_pkg::IRQ_MASK_OFFS))
                irq_mask_reg <= reg_bus.wdata[1:0];
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // read mux, unmapped reads zero
    always_comb
    begin
        unique case (reg_bus.addr)
            pirq_pkg::ENABLE_A_OFFS: rdata = enable_a_reg;
            pirq_pkg::ENABLE_B_OFFS: rdata = enable_b_reg;
            pirq_pkg::FLAGS_A_OFFS:  rdata = flags_a_reg;
            pirq_pkg::FLAGS_B_OFFS:  rdata = flags_b_reg;
            pirq_pkg::CORE_CTL_OFFS: rdata = core_ctl_reg;
            pirq_pkg::IRQ_STAT_OFFS: rdata = {6'h00, irq_stat_reg};
            pirq_pkg::IRQ_MASK_OFFS: rdata = {6'h00, irq_mask_reg};
            default:                 rdata = 8'h00;
        endcase
    end
    assign reg_bus.rdata = rdata;

    assign o_periph_pending = pending_reg;
    assign o_core_request   = request_reg;
    assign o_irq            = irq_reg;
endmodule

// ==== logic/pirq_req_gate.sv ====
// pirq_req_gate: combines flags, enables and core enables into requests.
// assumes flag and enable words already masked to implemented bits.
`timescale 1ns/1ps
module pirq_req_gate
(
    input  wire logic [7:0] i_flags_a,    // pending flags a
    input  wire logic [7:0] i_flags_b,    // pending flags b
    input  wire logic [7:0] i_enable_a,   // enables a
    input  wire logic [7:0] i_enable_b,   // enables b
    input  wire logic       i_periph_en,  // peripheral group enable
    input  wire logic       i_global_en,  // global enable
    output logic            o_any,        // any enabled flag pending
    output logic            o_redirect    // request reaching the core
);
    assign o_any      = |(i_flags_a & i_enable_a) || |(i_flags_b & i_enable_b);
    assign o_redirect = o_any && i_periph_en && i_global_en;
endmodule

// ==== shared/pirq_pkg.sv ====
// pirq_pkg: register map, field positions, reset values and interrupt layout
// of the peripheral interrupt enable/flag bank.
// assumes a 32-bit ahb-lite register bus, one aligned word per register.
package pirq_pkg;

    // register byte offsets
    localparam logic [11:0] ENABLE_A_OFFS = 12'h000;
    localparam logic [11:0] ENABLE_B_OFFS = 12'h004;
    localparam logic [11:0] FLAGS_A_OFFS  = 12'h008;
    localparam logic [11:0] FLAGS_B_OFFS  = 12'h00C;
    localparam logic [11:0] CORE_CTL_OFFS = 12'h010;
    localparam logic [11:0] IRQ_STAT_OFFS = 12'h014;
    localparam logic [11:0] IRQ_MASK_OFFS = 12'h018;

    // bit positions, pair a
    localparam int TIMER1_GATE_BIT     = 7;
    localparam int CONVERTER1_BIT      = 6;
    localparam int SERIAL_RX_BIT       = 5;
    localparam int SERIAL_TX_BIT       = 4;
    localparam int SYNC_SERIAL_BIT     = 3;
    localparam int TIMER2_MATCH_BIT    = 1;
    localparam int TIMER1_OVERFLOW_BIT = 0;
    // bit positions, pair b
    localparam int CONVERTER2_BIT      = 6;
    localparam int BUS_COLLISION_BIT   = 3;
    // core control positions
    localparam int GLOBAL_EN_BIT       = 7;
    localparam int PERIPH_EN_BIT       = 6;

    // implemented-bit masks
    localparam logic [7:0] IMPL_A_MASK = 8'hFB;
    localparam logic [7:0] IMPL_B_MASK = 8'h48;
    localparam logic [7:0] CORE_MASK   = 8'hC0;

    // reset values
    localparam logic [7:0] BANK_RESET  = 8'h00;
    localparam logic [1:0] IRQ_RESET   = 2'h0;

    // event status bits
    localparam int EV_REQ_RISE  = 0;
    localparam int EV_DEFERRED  = 1;

    // bus constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// ==== shared/pirq_reg_if.sv ====
// pirq_reg_if: decoded register access strobes between bus slave and bank.
// assumes one clock domain and one writer per strobe.
`timescale 1ns/1ps
interface pirq_reg_if;
    logic        wr_en;   // one-cycle write strobe
    logic [11:0] addr;    // byte offset of access
    logic [7:0]  wdata;   // low byte of write data
    logic [7:0]  rdata;   // low byte of read data

    modport slave_side
    (
        output wr_en,
        output addr,
        output wdata,
        input  rdata
    );
    modport bank_side
    (
        input  wr_en,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface

// ==== test/pirq_bank_asserts.sv ====
// pirq_bank_asserts: port-level checks bound into the interrupt bank.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module pirq_bank_asserts
(
    input wire logic        i_clk_sys,        // clock
    input wire logic        i_rst,            // reset
    input wire logic        i_ce,             // clock enable
    input wire logic        i_hsel,           // select
    input wire logic [31:0] i_haddr,          // address
    input wire logic [1:0]  i_htrans,         // transfer type
    input wire logic        i_hwrite,         // write
    input wire logic        i_hready,         // ready in
    input wire logic [31:0] o_hrdata,         // read data
    input wire logic        o_hreadyout,      // ready out
    input wire logic        o_hresp,          // response
    input wire logic        o_periph_pending, // enabled flag
    input wire logic        o_core_request,   // core request
    input wire logic        o_irq             // host line
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // read address phase to one register
    sequence rd_at(logic [11:0] offs);
        i_hsel && i_hready && i_ce && !i_hwrite && i_htrans == pirq_pkg::HTRANS_NONSEQ && i_haddr[11:0] == offs;
    endsequence

    // bits outside keep read zero in the data phase
    property rd_keeps(logic [11:0] offs, logic [7:0] keep);
        rd_at(offs) |=> (o_hrdata[7:0] & ~keep) == 8'h00;
    endproperty

    a_ready_always:
        assert property (o_hreadyout) else $error("ready out low");
    a_resp_okay:
        assert property (!o_hresp) else $error("error response");
    a_upper_zero:
        assert property (o_hrdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_reset_clears:
        assert property (disable iff (1'b0) i_rst && i_ce |=> !o_periph_pending && !o_core_request && !o_irq)
        else $error("output set after reset");
    a_req_needs_pend:
        assert property (o_core_request |-> o_periph_pending) else $error("request without pending");
    a_enable_a_bits:
        assert property (rd_keeps(pirq_pkg::ENABLE_A_OFFS, pirq_pkg::IMPL_A_MASK)) else $error("enable a stray");
    a_enable_b_bits:
        assert property (rd_keeps(pirq_pkg::ENABLE_B_OFFS, pirq_pkg::IMPL_B_MASK)) else $error("enable b stray");
    a_flags_a_bits:
        assert property (rd_keeps(pirq_pkg::FLAGS_A_OFFS, pirq_pkg::IMPL_A_MASK)) else $error("flags a stray");
    a_flags_b_bits:
        assert property (rd_keeps(pirq_pkg::FLAGS_B_OFFS, pirq_pkg::IMPL_B_MASK)) else $error("flags b stray");
    a_unmapped_zero:
        assert property (rd_keeps(12'h01C, 8'h00)) else $error("unmapped read not zero");
endmodule

bind pirq_bank pirq_bank_asserts chk_u
(
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_periph_pending(o_periph_pending), .o_core_request(o_core_request), .o_irq(o_irq)
);

// ==== test/pirq_periph_model.sv ====
// pirq_periph_model: on-chip peripherals raising one-cycle event pulses.
// assumes requests arrive on the system clock, bits at flag positions.
`timescale 1ns/1ps
module pirq_periph_model
(
    input  wire logic        i_clk_sys,        // system clock
    input  wire logic [15:0] i_fire,           // requested events
    output logic      [15:0] o_event = 16'h0000 // pulses to bank
);
    // each requested source pulses one cycle after the request
    always @(posedge i_clk_sys)
    begin
        o_event <= i_fire;
    end
endmodule

// ==== test/tb.sv ====
// tb: self-checking bench for the peripheral interrupt bank.
// assumes the bound checker and the peripheral event model.
`timescale 1ns/1ps
module tb;
    typedef struct { logic [11:0] a; logic [7:0] w; logic [7:0] r; } pirq_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  ctl [3] = '{8'h40, 8'h80, 8'hC0};
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic [31:0] rd_q;
    logic [31:0] rd;
    logic [15:0] fire = 16'h0000;
    logic [15:0] ev;
    logic [2:0]  outs_q;
    logic        hready;
    logic        pend;
    logic        creq;
    logic        irq;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    pirq_row_t   rows [11] = '{
        '{pirq_pkg::ENABLE_A_OFFS, 8'hFF, 8'hFB}, '{pirq_pkg::ENABLE_B_OFFS, 8'hFF, 8'h48},
        '{pirq_pkg::FLAGS_A_OFFS, 8'hFF, 8'hFB}, '{pirq_pkg::FLAGS_B_OFFS, 8'hFF, 8'h48},
        '{pirq_pkg::CORE_CTL_OFFS, 8'hFF, 8'hC0}, '{12'h01C, 8'hFF, 8'h00},
        '{pirq_pkg::FLAGS_A_OFFS, 8'h00, 8'h00}, '{pirq_pkg::FLAGS_B_OFFS, 8'h00, 8'h00},
        '{pirq_pkg::ENABLE_A_OFFS, 8'h00, 8'h00}, '{pirq_pkg::ENABLE_B_OFFS, 8'h00, 8'h00},
        '{pirq_pkg::CORE_CTL_OFFS, 8'h00, 8'h00}};

    always #2 clk = ~clk;

    // settled copies of outputs, taken mid-cycle
    always @(negedge clk)
    begin
        rd_q = hrdata;
        outs_q = {pend, creq, irq};
    end

    pirq_bank dut_u
    (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
        .i_timer1_gate(ev[7]), .i_converter1(ev[6]), .i_serial_rx(ev[5]), .i_serial_tx(ev[4]),
        .i_sync_serial(ev[3]), .i_timer2_match(ev[1]), .i_timer1_overflow(ev[0]),
        .i_converter2(ev[14]), .i_bus_collision(ev[11]),
        .o_periph_pending(pend), .o_core_request(creq), .o_irq(irq)
    );

    pirq_periph_model periph_u (.i_clk_sys(clk), .i_fire(fire), .o_event(ev));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single-word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] w);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= pirq_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= pirq_pkg::HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, w};
        do @(posedge clk); while (hready !== 1'b1);
        rd = rd_q;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse(input logic [15:0] m);
        fire <= m;
        tick(1);
        fire <= 16'h0000;
        tick(3);
    endtask

    initial
    begin
        tick(2);
        rst <= 1'b0;
        // every register starts cleared
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, 12'(i * 4), 8'h00);
            check(rd, 32'h00000000);
        end
        check({29'h0, outs_q}, 32'h0);
        // write and read back the enable, flag and core control registers and one unmapped offset
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].w);
            bus(1'b0, rows[i].a, 8'h00);
            check(rd, {24'h0, rows[i].r});
        end
        bus(1'b1, pirq_pkg::IRQ_STAT_OFFS, 8'h03);
        // all sources fire with every enable off
        pulse(16'h48FB);
        bus(1'b0, pirq_pkg::FLAGS_A_OFFS, 8'h00);
        check(rd, 32'hFB);
        bus(1'b0, pirq_pkg::FLAGS_B_OFFS, 8'h00);
        check(rd, 32'h48);
        check({29'h0, outs_q}, 32'h0);
        // clear before enabling, then one source through the core enables
        bus(1'b1, pirq_pkg::FLAGS_A_OFFS, 8'h00);
        bus(1'b1, pirq_pkg::ENABLE_A_OFFS, 8'h02);
        pulse(16'h0002);
        check({29'h0, outs_q}, 32'h4);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, pirq_pkg::CORE_CTL_OFFS, ctl[i]);
            tick(2);
            check({31'h0, outs_q[1]}, {31'h0, i == 2});
        end
        // sticky status, mask and clear of the host line
        bus(1'b1, pirq_pkg::IRQ_MASK_OFFS, 8'h01);
        tick(2);
        check({31'h0, outs_q[0]}, 32'h1);
        bus(1'b0, pirq_pkg::IRQ_STAT_OFFS, 8'h00);
        check(rd, 32'h3);
        bus(1'b1, pirq_pkg::IRQ_STAT_OFFS, 8'h03);
        tick(2);
        check({31'h0, outs_q[0]}, 32'h0);
        bus(1'b1, pirq_pkg::CORE_CTL_OFFS, 8'h00);
        tick(2);
        check({31'h0, outs_q[0]}, 32'h0);
        bus(1'b1, pirq_pkg::IRQ_MASK_OFFS, 8'h02);
        tick(2);
        check({31'h0, outs_q[0]}, 32'h1);
        // service: clear the flag, pending drops
        bus(1'b1, pirq_pkg::FLAGS_A_OFFS, 8'h00);
        bus(1'b1, pirq_pkg::IRQ_STAT_OFFS, 8'h03);
        tick(2);
        check({29'h0, outs_q}, 32'h0);
        // second reset in mid-run
        bus(1'b1, pirq_pkg::ENABLE_B_OFFS, 8'h48);
        pulse(16'h4000);
        check({29'h0, outs_q}, 32'h5);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        bus(1'b0, pirq_pkg::ENABLE_B_OFFS, 8'h00);
        check(rd, 32'h0);
        bus(1'b0, pirq_pkg::FLAGS_B_OFFS, 8'h00);
        check(rd, 32'h0);
        check({29'h0, outs_q}, 32'h0);
        // clock enable low: an event pulse is not recorded
        ce <= 1'b0;
        pulse(16'h0001);
        ce <= 1'b1;
        bus(1'b0, pirq_pkg::FLAGS_A_OFFS, 8'h00);
        check(rd, 32'h0);
        report_and_stop();
    end
endmodule
